// file: src/compact_timer_defs.vh
// Purpose: Shared constants of the compact 10-bit timer: offsets, fields, codes.
// Assumes: Included by bare name from the timer core and from its testbench.
// Notes: Byte offsets are word aligned for the AXI4-Lite register slave.
`ifndef COMPACT_TIMER_DEFS_VH
`define COMPACT_TIMER_DEFS_VH

`define CT_OFS_CTRL_MAIN 8'h00
`define CT_OFS_MODE_CTRL 8'h04
`define CT_OFS_COUNT_LOW 8'h08
`define CT_OFS_COUNT_HIGH 8'h0C
`define CT_OFS_CMPA_LOW 8'h10
`define CT_OFS_CMPA_HIGH 8'h14

`define CT_RST_BYTE 8'h00
`define CT_RST_WORD10 10'h000
`define CT_HIGH_PAD 6'h00
`define CT_RD_ZERO 32'h00000000
`define CT_WORD_PAD 24'h000000

`define CT_BIT_HOLD 7
`define CT_CKS_HI 6
`define CT_CKS_LO 4
`define CT_BIT_RUN 3
`define CT_RP_HI 2
`define CT_RP_LO 0

`define CT_MODE_HI 7
`define CT_MODE_LO 6
`define CT_IO_HI 5
`define CT_IO_LO 4
`define CT_BIT_OC 3
`define CT_BIT_POL 2
`define CT_BIT_DPX 1
`define CT_BIT_CCLR 0

`define CT_CKS_SYS_DIV4 3'h0
`define CT_CKS_SYS 3'h1
`define CT_CKS_HI_DIV16 3'h2
`define CT_CKS_HI_DIV64 3'h3
`define CT_CKS_TIMEBASE 3'h4
`define CT_CKS_RESERVED 3'h5
`define CT_CKS_EXT_RISE 3'h6
`define CT_CKS_EXT_FALL 3'h7

`define CT_MODE_COMPARE 2'h0
`define CT_MODE_PWM 2'h2

`define CT_IO_NONE 2'h0
`define CT_IO_LOW 2'h1
`define CT_IO_HIGH 2'h2
`define CT_IO_TOGGLE 2'h3

`define CT_SYS_DIV_LAST 2'h3
`define CT_HI16_LAST 4'hF
`define CT_HI64_LAST 6'h3F
`define CT_PERIOD_LOW_ZERO 7'h00

`define CT_RESP_OKAY 2'h0
`define CT_RESP_SLVERR 2'h2

`endif

// file: src/pin_edge_sync.v
// Purpose: Brings an asynchronous pin into the clock domain and flags its edges.
// Assumes: One clock; clock enable low freezes every stage.
// Notes: Edges appear two clock-enabled cycles after the pin moves.
`timescale 1ns/1ps
`default_nettype none
module pin_edge_sync (
  input wire sys_clk_i,
  input wire resetn_i,
  input wire ce_i,
  input wire pin_i,
  output wire rise_o,
  output wire fall_o
);
  reg meta;
  reg stable;
  reg last;

  // The first stage feeds only the second, so a metastable value never fans out.
  always @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      meta <= 1'b0;
      stable <= 1'b0;
      last <= 1'b0;
    end
    else if (ce_i)
    begin
      meta <= pin_i;
      stable <= meta;
      last <= stable;
    end
  end

  assign rise_o = ce_i & stable & ~last;
  assign fall_o = ce_i & ~stable & last;
endmodule
`default_nettype wire

// file: src/compact_timer.v
// Purpose: Compact 10-bit count-up timer with AXI4-Lite registers.
// Assumes: sys_clk_i at 125 MHz; tick inputs are one-cycle enables on it.
// Notes: Registers hold data in bits 7..0 of each word; upper bits read zero.
// Overview of operation
// - Ten-bit counter counts up on selected clock.
// - Clock select picks divided, internal or pin.
// - P checks top three bits; A all ten.
// - Software clears counter only via run enable.
// - Overflow or selected match clears counter; only matches raise events.
// - Hold bit freezes count; release resumes counting.
// - Count readable only; high byte upper zero.
// - Low write buffers; high write commits both.
// - High read captures low into shared buffer.
// - Pin drives counter only when selected.
// - Compare mode sets, clears or toggles output.
// - PWM waveform leaves on the same pin.
// - Pin enabled by run in compare or PWM mode.
// - Output pin and inverted twin provided.
// - Modes: compare output, timer, PWM only.
// - Run rise zeroes counter; fall keeps value.
// - Run rise restores compare-mode initial level.
// - Period code n is n times 128; code zero gives 1024.
// - Clear select zero clears on P match outside PWM mode.
`timescale 1ns/1ps
`default_nettype none
`include "compact_timer_defs.vh"
module compact_timer #(
  parameter CNT_W = 10
) (
  input wire sys_clk_i,
  input wire resetn_i,
  input wire ce_i,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire high_clock_tick_i,
  input wire timebase_tick_i,
  input wire ext_clock_pin_i,
  output wire timer_output_pin_o,
  output wire timer_output_pin_n_o,
  output wire timer_output_pin_oe_o,
  output wire match_p_o,
  output wire match_a_o
);
  reg [7:0] counter_ctrl_main, counter_mode_ctrl, byte_buf;
  reg [CNT_W-1:0] duty_compare_value, count;
  reg [1:0] sys_div;
  reg [5:0] high_div;
  reg run_last, out_level, pin_level, pin_level_n, pin_oe, match_p, match_a;

  reg aw_held, w_held, w_lane0, bvalid, rvalid;
  reg [7:0] aw_addr, w_byte;
  reg [1:0] bresp, rresp;
  reg [31:0] rdata;

  wire ext_rise, ext_fall;
  wire [2:0] clock_select = counter_ctrl_main[`CT_CKS_HI:`CT_CKS_LO];
  wire [2:0] period_compare_value = counter_ctrl_main[`CT_RP_HI:`CT_RP_LO];
  wire counter_run_enable = counter_ctrl_main[`CT_BIT_RUN];
  wire counter_hold = counter_ctrl_main[`CT_BIT_HOLD];
  wire [1:0] mode_select = counter_mode_ctrl[`CT_MODE_HI:`CT_MODE_LO];
  wire [1:0] output_action = counter_mode_ctrl[`CT_IO_HI:`CT_IO_LO];
  wire output_initial_level = counter_mode_ctrl[`CT_BIT_OC];
  wire output_polarity = counter_mode_ctrl[`CT_BIT_POL];
  wire duty_period_swap = counter_mode_ctrl[`CT_BIT_DPX];
  wire clear_source_select = counter_mode_ctrl[`CT_BIT_CCLR];

  // Mode codes other than compare and PWM all behave as the plain timer.
  wire mode_compare = (mode_select == `CT_MODE_COMPARE);
  wire mode_pwm = (mode_select == `CT_MODE_PWM);

  pin_edge_sync u_ext_sync (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .pin_i(ext_clock_pin_i),
    .rise_o(ext_rise),
    .fall_o(ext_fall)
  );

  // Counter clock selection.
  wire sys_div_tick = (sys_div == `CT_SYS_DIV_LAST);
  wire hi16_tick = high_clock_tick_i & (high_div[3:0] == `CT_HI16_LAST);
  wire hi64_tick = high_clock_tick_i & (high_div == `CT_HI64_LAST);
  reg count_tick;

  always @*
  begin
    count_tick = 1'b0;
    case (clock_select)
      `CT_CKS_SYS_DIV4: count_tick = sys_div_tick;
      `CT_CKS_SYS: count_tick = 1'b1;
      `CT_CKS_HI_DIV16: count_tick = hi16_tick;
      `CT_CKS_HI_DIV64: count_tick = hi64_tick;
      `CT_CKS_TIMEBASE: count_tick = timebase_tick_i;
      `CT_CKS_RESERVED: count_tick = 1'b0;
      `CT_CKS_EXT_RISE: count_tick = ext_rise;
      `CT_CKS_EXT_FALL: count_tick = ext_fall;
      default: count_tick = 1'b0;
    endcase
  end

  always @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sys_div <= 2'h0;
      high_div <= 6'h00;
    end
    else if (ce_i)
    begin
      sys_div <= sys_div + 2'h1;
      if (high_clock_tick_i)
      begin
        high_div <= high_div + 6'h01;
      end
    end
  end

  // Comparators look at the value the counter is about to take.
  wire [CNT_W-1:0] next_count_raw = count + {{(CNT_W-1){1'b0}}, 1'b1};
  // Code zero matches only at wrap, which gives the full 1024-clock period.
  wire p_hit = (next_count_raw[CNT_W-1:CNT_W-3] == period_compare_value) &&
    (next_count_raw[CNT_W-4:0] == `CT_PERIOD_LOW_ZERO);
  wire a_hit = (next_count_raw == duty_compare_value);
  wire run_rise = counter_run_enable & ~run_last;
  wire advance = counter_run_enable & ~counter_hold & count_tick;
  wire clear_by_a = mode_pwm ? duty_period_swap : clear_source_select;
  wire clear_hit = clear_by_a ? a_hit : p_hit;

  // Natural wrap of the ten bits covers overflow when no match fires first.
  always @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      count <= `CT_RST_WORD10;
      run_last <= 1'b0;
      match_p <= 1'b0;
      match_a <= 1'b0;
    end
    else if (ce_i)
    begin
      run_last <= counter_run_enable;
      match_p <= advance & ~run_rise & p_hit;
      match_a <= advance & ~run_rise & a_hit;
      if (run_rise)
      begin
        count <= `CT_RST_WORD10;
      end
      else if (advance)
      begin
        count <= clear_hit ? `CT_RST_WORD10 : next_count_raw;
      end
    end
  end

  // Output waveform generation.
  wire [CNT_W-1:0] pwm_duty = duty_period_swap ?
    {period_compare_value, `CT_PERIOD_LOW_ZERO} : duty_compare_value;
  reg next_out_level;

  always @*
  begin
    next_out_level = out_level;
    if (mode_compare)
    begin
      if (run_rise)
      begin
        next_out_level = output_initial_level;
      end
      else if (advance && a_hit)
      begin
        case (output_action)
          `CT_IO_NONE: next_out_level = out_level;
          `CT_IO_LOW: next_out_level = 1'b0;
          `CT_IO_HIGH: next_out_level = 1'b1;
          `CT_IO_TOGGLE: next_out_level = ~out_level;
          default: next_out_level = out_level;
        endcase
      end
    end
    else if (mode_pwm)
    begin
      case (output_action)
        `CT_IO_NONE: next_out_level = 1'b0;
        `CT_IO_LOW: next_out_level = 1'b1;
        default: next_out_level = (count < pwm_duty);
      endcase
    end
  end

  // The pin lags the internal level by one cycle so that it leaves a flop.
  always @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      out_level <= 1'b0;
      pin_level <= 1'b0;
      pin_level_n <= 1'b1;
      pin_oe <= 1'b0;
    end
    else if (ce_i)
    begin
      out_level <= next_out_level;
      pin_level <= out_level ^ output_polarity;
      pin_level_n <= ~(out_level ^ output_polarity);
      pin_oe <= counter_run_enable & (mode_compare | mode_pwm);
    end
  end

  assign timer_output_pin_o = pin_level;
  assign timer_output_pin_n_o = pin_level_n;
  assign timer_output_pin_oe_o = pin_oe;
  assign match_p_o = match_p;
  assign match_a_o = match_a;

  // AXI4-Lite slave. Readies drop with the clock enable so nothing is lost.
  assign s_axi_awready = ce_i & ~aw_held & ~bvalid;
  assign s_axi_wready = ce_i & ~w_held & ~bvalid;
  assign s_axi_arready = ce_i & ~rvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rresp = rresp;
  assign s_axi_rdata = rdata;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire wr_commit = ce_i & aw_held & w_held & ~bvalid;
  wire wr_byte = wr_commit & w_lane0;
  wire wr_known = (aw_addr == `CT_OFS_CTRL_MAIN) || (aw_addr == `CT_OFS_MODE_CTRL) ||
    (aw_addr == `CT_OFS_COUNT_LOW) || (aw_addr == `CT_OFS_COUNT_HIGH) ||
    (aw_addr == `CT_OFS_CMPA_LOW) || (aw_addr == `CT_OFS_CMPA_HIGH);
  reg rd_known;
  reg [7:0] rd_byte;

  always @*
  begin
    rd_known = 1'b1;
    rd_byte = `CT_RST_BYTE;
    case (s_axi_araddr)
      `CT_OFS_CTRL_MAIN: rd_byte = counter_ctrl_main;
      `CT_OFS_MODE_CTRL: rd_byte = counter_mode_ctrl;
      `CT_OFS_COUNT_LOW: rd_byte = byte_buf;
      `CT_OFS_COUNT_HIGH: rd_byte = {`CT_HIGH_PAD, count[CNT_W-1:8]};
      `CT_OFS_CMPA_LOW: rd_byte = byte_buf;
      `CT_OFS_CMPA_HIGH: rd_byte = {`CT_HIGH_PAD, duty_compare_value[CNT_W-1:8]};
      default: rd_known = 1'b0;
    endcase
  end

  always @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      aw_held <= 1'b0;
      aw_addr <= `CT_RST_BYTE;
      w_held <= 1'b0;
      w_byte <= `CT_RST_BYTE;
      w_lane0 <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `CT_RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= `CT_RESP_OKAY;
      rdata <= `CT_RD_ZERO;
    end
    else if (ce_i)
    begin
      if (aw_take)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_take)
      begin
        w_held <= 1'b1;
        w_byte <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (wr_commit)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_known ? `CT_RESP_OKAY : `CT_RESP_SLVERR;
      end
      else if (bvalid && s_axi_bready)
      begin
        bvalid <= 1'b0;
      end
      if (ar_take)
      begin
        rvalid <= 1'b1;
        rresp <= rd_known ? `CT_RESP_OKAY : `CT_RESP_SLVERR;
        rdata <= rd_known ? {`CT_WORD_PAD, rd_byte} : `CT_RD_ZERO;
      end
      else if (rvalid && s_axi_rready)
      begin
        rvalid <= 1'b0;
      end
    end
  end

  // Register storage. The count registers ignore writes entirely.
  // A compare-A low-byte write and a high-byte read in the same cycle both aim at the buffer;
  // software must not overlap them, and the write is kept when it happens.
  always @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      counter_ctrl_main <= `CT_RST_BYTE;
      counter_mode_ctrl <= `CT_RST_BYTE;
      duty_compare_value <= `CT_RST_WORD10;
      byte_buf <= `CT_RST_BYTE;
    end
    else if (ce_i)
    begin
      if (wr_byte && aw_addr == `CT_OFS_CTRL_MAIN)
      begin
        counter_ctrl_main <= w_byte;
      end
      if (wr_byte && aw_addr == `CT_OFS_MODE_CTRL)
      begin
        counter_mode_ctrl <= w_byte;
      end
      if (wr_byte && aw_addr == `CT_OFS_CMPA_HIGH)
      begin
        duty_compare_value <= {w_byte[CNT_W-9:0], byte_buf};
      end
      if (wr_byte && aw_addr == `CT_OFS_CMPA_LOW)
      begin
        byte_buf <= w_byte;
      end
      else if (ar_take && s_axi_araddr == `CT_OFS_COUNT_HIGH)
      begin
        byte_buf <= count[7:0];
      end
      else if (ar_take && s_axi_araddr == `CT_OFS_CMPA_HIGH)
      begin
        byte_buf <= duty_compare_value[7:0];
      end
    end
  end
endmodule
`default_nettype wire

// file: sim/compact_timer_properties.sv
// Purpose: Port-level checks of the compact timer bus and output pins.
// Assumes: Bound to compact_timer; one clock domain, reset active low.
// Notes: Configuration is internal, so checks stay on port relations.
`timescale 1ns/1ps
`default_nettype none
module compact_timer_properties #(
  parameter CNT_W = 10
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer_output_pin_o,
  input wire logic timer_output_pin_n_o,
  input wire logic match_p_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);
  sequence ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence aw_w_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_read_answer: assert property (ar_take |=> s_axi_rvalid)
    else $error("read not answered one cycle after address");
  a_write_answer: assert property (aw_w_take |=> ##1 s_axi_bvalid)
    else $error("write not answered two cycles after transfer");
  a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped or changed before taken");
  a_write_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped or changed before taken");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address accepted while read answer pending");
  a_rdata_upper_zero: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_pin_twin_inverse: assert property (timer_output_pin_n_o == !timer_output_pin_o)
    else $error("twin output pin is not the inverse");
  a_period_gap: assert property (match_p_o |=> !match_p_o [*8])
    else $error("period match pulses too close together");
endmodule
bind compact_timer compact_timer_properties #(.CNT_W(CNT_W)) compact_timer_properties_inst (
  .sys_clk_i(sys_clk_i),
  .resetn_i(resetn_i),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .timer_output_pin_o(timer_output_pin_o),
  .timer_output_pin_n_o(timer_output_pin_n_o),
  .match_p_o(match_p_o)
);
`default_nettype wire

// file: sim/test_compact_timer.sv
// Purpose: Self-checking bench of the compact timer through its AXI4-Lite registers.
// Assumes: Clock enable held high; ticks and the pin are driven by the bench.
// Notes: Pulse waits are bounded; a bus hang ends through the watchdog.
`timescale 1ns/1ps
`default_nettype none
`include "compact_timer_defs.vh"
module test_compact_timer;
  logic sys_clk_i, resetn_i, ce_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic high_clock_tick_i, timebase_tick_i, ext_clock_pin_i, match_p_o, match_a_o;
  logic timer_output_pin_o, timer_output_pin_n_o, timer_output_pin_oe_o;
  logic [9:0] v1, v2;
  int n_mismatch, num_checks, n, cnt;
  compact_timer compact_timer_inst (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .high_clock_tick_i(high_clock_tick_i), .timebase_tick_i(timebase_tick_i),
    .ext_clock_pin_i(ext_clock_pin_i), .timer_output_pin_o(timer_output_pin_o),
    .timer_output_pin_n_o(timer_output_pin_n_o), .timer_output_pin_oe_o(timer_output_pin_oe_o),
    .match_p_o(match_p_o), .match_a_o(match_a_o)
  );
  task automatic fail(input string msg);
    n_mismatch++;
    $display("mismatch at %0t: %s", $time, msg);
  endtask
  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
      fail($sformatf("value %0h, expected %0h", got, exp));
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    num_checks++;
    if (got !== exp)
      fail($sformatf("response %0h, expected %0h", got, exp));
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
      fail($sformatf("pin level %b, expected %b", got, exp));
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] dat, input logic [1:0] er);
    logic ta, tw, tk;
    logic [1:0] r;
    @(posedge sys_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, dat};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(negedge sys_clk_i);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tk = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge sys_clk_i);
      if (ta)
        s_axi_awvalid <= 1'h0;
      if (tw)
        s_axi_wvalid <= 1'h0;
    end
    while (!tk);
    s_axi_bready <= 1'h0;
    chk_resp(r, er);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] dat, input logic [1:0] er);
    logic ta, tk;
    logic [1:0] r;
    @(posedge sys_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(negedge sys_clk_i);
      ta = s_axi_arvalid & s_axi_arready;
      tk = s_axi_rvalid;
      dat = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge sys_clk_i);
      if (ta)
        s_axi_arvalid <= 1'h0;
    end
    while (!tk);
    s_axi_rready <= 1'h0;
    chk_resp(r, er);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] dat;
    rd(a, dat, `CT_RESP_OKAY);
    chk_data(dat, exp);
  endtask
  // High byte first so the shared buffer holds the matching low byte.
  task automatic rd_count(output logic [9:0] v);
    logic [31:0] dat;
    rd(`CT_OFS_COUNT_HIGH, dat, `CT_RESP_OKAY);
    v[9:8] = dat[1:0];
    rd(`CT_OFS_COUNT_LOW, dat, `CT_RESP_OKAY);
    v[7:0] = dat[7:0];
  endtask
  task automatic wait_pulse(input logic sel, output int k);
    k = 0;
    do
    begin
      @(negedge sys_clk_i);
      k++;
    end
    while (k < 5000 && (sel ? match_a_o : match_p_o) !== 1'h1);
  endtask
  task automatic measure(input logic sel, input int exp);
    int k;
    wait_pulse(sel, k);
    wait_pulse(sel, k);
    chk_data(k, exp);
  endtask
  task automatic src_test(input logic [2:0] cks, input int nhi, input int ntb, input int ntog,
                          input int ex);
    logic [9:0] v;
    wr(`CT_OFS_CTRL_MAIN, {1'h0, cks, 4'h0}, `CT_RESP_OKAY);
    wr(`CT_OFS_CTRL_MAIN, {1'h0, cks, 4'h8}, `CT_RESP_OKAY);
    for (int i = 0; i < 256; i++)
    begin
      @(posedge sys_clk_i);
      high_clock_tick_i <= i[0] && i < 2 * nhi;
      timebase_tick_i <= i[0] && i < 2 * ntb;
      if (i % 8 == 0 && i < 8 * ntog)
        ext_clock_pin_i <= !ext_clock_pin_i;
    end
    @(posedge sys_clk_i);
    high_clock_tick_i <= 1'h0;
    timebase_tick_i <= 1'h0;
    // The pin needs a few cycles through its synchroniser before it counts.
    repeat (8) @(posedge sys_clk_i);
    rd_count(v);
    chk_data({22'h000000, v}, ex);
    ext_clock_pin_i <= 1'h0;
  endtask
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    sys_clk_i = 1'h0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  initial
  begin
    repeat (60000) @(posedge sys_clk_i);
    n_mismatch++;
    wrap_up;
  end
  initial
  begin
    {resetn_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {high_clock_tick_i, timebase_tick_i, ext_clock_pin_i} = 3'h0;
    ce_i = 1'h1;
    s_axi_wstrb = 4'hF;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h00000000;
    repeat (4) @(posedge sys_clk_i);
    resetn_i <= 1'h1;
    rd_chk(`CT_OFS_CTRL_MAIN, 32'h00000000);
    rd_chk(`CT_OFS_COUNT_HIGH, 32'h00000000);
    rd_chk(`CT_OFS_COUNT_LOW, 32'h00000000);
    rd_chk(`CT_OFS_CMPA_HIGH, 32'h00000000);
    rd_chk(`CT_OFS_CMPA_LOW, 32'h00000000);
    rd(8'h18, d, `CT_RESP_SLVERR);
    chk_data(d, 32'h00000000);
    wr(8'h18, 8'hFF, `CT_RESP_SLVERR);
    wr(`CT_OFS_CTRL_MAIN, 8'h5F, `CT_RESP_OKAY);
    rd_chk(`CT_OFS_CTRL_MAIN, 32'h0000005F);
    wr(`CT_OFS_MODE_CTRL, 8'h5A, `CT_RESP_OKAY);
    rd_chk(`CT_OFS_MODE_CTRL, 32'h0000005A);
    wr(`CT_OFS_MODE_CTRL, 8'h00, `CT_RESP_OKAY);
    wr(`CT_OFS_COUNT_LOW, 8'hFF, `CT_RESP_OKAY);
    wr(`CT_OFS_COUNT_HIGH, 8'h03, `CT_RESP_OKAY);
    rd_chk(`CT_OFS_COUNT_HIGH, 32'h00000000);
    rd_chk(`CT_OFS_COUNT_LOW, 32'h00000000);
    wr(`CT_OFS_CMPA_LOW, 8'h5A, `CT_RESP_OKAY);
    wr(`CT_OFS_CMPA_HIGH, 8'hFF, `CT_RESP_OKAY);
    rd_chk(`CT_OFS_CMPA_HIGH, 32'h00000003);
    rd_chk(`CT_OFS_CMPA_LOW, 32'h0000005A);
    wr(`CT_OFS_CMPA_LOW, 8'hA5, `CT_RESP_OKAY);
    rd_chk(`CT_OFS_CMPA_HIGH, 32'h00000003);
    rd_chk(`CT_OFS_CMPA_LOW, 32'h0000005A);
    src_test(`CT_CKS_HI_DIV16, 32, 0, 3, 2);
    src_test(`CT_CKS_HI_DIV64, 128, 0, 0, 2);
    src_test(`CT_CKS_TIMEBASE, 20, 5, 3, 5);
    src_test(`CT_CKS_RESERVED, 20, 5, 3, 0);
    src_test(`CT_CKS_EXT_RISE, 0, 0, 5, 3);
    src_test(`CT_CKS_EXT_FALL, 0, 0, 5, 2);
    wr(`CT_OFS_CTRL_MAIN, 8'h19, `CT_RESP_OKAY);
    measure(1'h0, 128);
    wr(`CT_OFS_CTRL_MAIN, 8'h18, `CT_RESP_OKAY);
    measure(1'h0, 1024);
    wr(`CT_OFS_CTRL_MAIN, 8'h09, `CT_RESP_OKAY);
    measure(1'h0, 512);
    wr(`CT_OFS_MODE_CTRL, 8'h39, `CT_RESP_OKAY);
    wr(`CT_OFS_CMPA_LOW, 8'hC8, `CT_RESP_OKAY);
    wr(`CT_OFS_CMPA_HIGH, 8'h00, `CT_RESP_OKAY);
    wr(`CT_OFS_CTRL_MAIN, 8'h10, `CT_RESP_OKAY);
    wr(`CT_OFS_CTRL_MAIN, 8'h18, `CT_RESP_OKAY);
    repeat (2) @(negedge sys_clk_i);
    chk_bit(timer_output_pin_o, 1'h1);
    chk_bit(timer_output_pin_oe_o, 1'h1);
    wait_pulse(1'h1, n);
    repeat (3) @(negedge sys_clk_i);
    chk_bit(timer_output_pin_o, 1'h0);
    measure(1'h1, 200);
    wr(`CT_OFS_CTRL_MAIN, 8'h98, `CT_RESP_OKAY);
    rd_count(v1);
    repeat (20) @(posedge sys_clk_i);
    rd_count(v2);
    chk_data(v2, v1);
    wr(`CT_OFS_CTRL_MAIN, 8'h18, `CT_RESP_OKAY);
    rd_count(v2);
    chk_bit(v2 > v1, 1'h1);
    wr(`CT_OFS_CTRL_MAIN, 8'h10, `CT_RESP_OKAY);
    rd_count(v1);
    repeat (20) @(posedge sys_clk_i);
    rd_count(v2);
    chk_data(v2, v1);
    repeat (2) @(negedge sys_clk_i);
    chk_bit(timer_output_pin_oe_o, 1'h0);
    wr(`CT_OFS_CTRL_MAIN, 8'h98, `CT_RESP_OKAY);
    rd_count(v1);
    chk_data(v1, 32'h00000000);
    wr(`CT_OFS_MODE_CTRL, 8'h79, `CT_RESP_OKAY);
    repeat (2) @(negedge sys_clk_i);
    chk_bit(timer_output_pin_oe_o, 1'h0);
    wr(`CT_OFS_CMPA_LOW, 8'h40, `CT_RESP_OKAY);
    wr(`CT_OFS_CMPA_HIGH, 8'h00, `CT_RESP_OKAY);
    wr(`CT_OFS_MODE_CTRL, 8'hA0, `CT_RESP_OKAY);
    wr(`CT_OFS_CTRL_MAIN, 8'h10, `CT_RESP_OKAY);
    wr(`CT_OFS_CTRL_MAIN, 8'h19, `CT_RESP_OKAY);
    wait_pulse(1'h0, n);
    cnt = 0;
    // A whole period of samples gives the duty count whatever the pin latency.
    repeat (128)
    begin
      @(negedge sys_clk_i);
      cnt += (timer_output_pin_o === 1'h1);
    end
    chk_data(cnt, 64);
    chk_bit(timer_output_pin_oe_o, 1'h1);
    // Forced active level with inverted polarity, then forced inactive.
    wr(`CT_OFS_MODE_CTRL, 8'h94, `CT_RESP_OKAY);
    repeat (2) @(negedge sys_clk_i);
    chk_bit(timer_output_pin_o, 1'h0);
    chk_bit(timer_output_pin_n_o, 1'h1);
    wr(`CT_OFS_MODE_CTRL, 8'h84, `CT_RESP_OKAY);
    repeat (2) @(negedge sys_clk_i);
    chk_bit(timer_output_pin_o, 1'h1);
    chk_bit(timer_output_pin_n_o, 1'h0);
    wrap_up;
  end
endmodule
`default_nettype wire
